// File: include/calsbo_pkg.sv
/*
  Shared constants and types of the cpu execution datapath: operation codes,
  operand sizes, flag positions, field masks and controller states.
  Assumes it is compiled before every design file that imports it.
*/
package calsbo_pkg;

  // operation codes as presented on the command port
  typedef enum logic [4:0] {
    unsigned_divide_op,
    signed_divide_op,
    compare_op,
    negate_op,
    sign_extend_op,
    zero_extend_op,
    and_op,
    or_op,
    xor_op,
    complement_op,
    arith_left_shift_op,
    arith_right_shift_op,
    logic_left_shift_op,
    logic_right_shift_op,
    rotate_left_op,
    rotate_right_op,
    carry_rotate_left_op,
    carry_rotate_right_op,
    bit_force_one_op,
    bit_force_zero_op,
    bit_toggle_op,
    bit_probe_op,
    bit_and_carry_op,
    inverted_bit_and_carry_op
  } calsbo_op_t;

  // controller states, gray along idle-exec-write
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_MEMWR = 2'h3,
    ST_MEMRD = 2'h2
  } calsbo_state_t;

  // operand sizes
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  // widths
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned GREG_AW = 3;
  localparam int unsigned GREG_COUNT = 8;
  localparam int unsigned BITNO_W = 3;

  // positions of the condition_code_flags bits
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_V = 1;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_N = 3;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  // field masks, msb positions and upper-half shifts
  localparam logic [31:0] MASK_BYTE = 32'h0000_00ff;
  localparam logic [31:0] MASK_WORD = 32'h0000_ffff;
  localparam logic [31:0] MASK_LONG = 32'hffff_ffff;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [31:0] WORD_ONE = 32'h0000_0001;
  localparam logic [4:0] TOP_BYTE = 5'h07;
  localparam logic [4:0] TOP_WORD = 5'h0f;
  localparam logic [4:0] TOP_LONG = 5'h1f;
  localparam logic [4:0] SH_NONE = 5'h00;
  localparam logic [4:0] SH_BYTE_HI = 5'h08;
  localparam logic [4:0] SH_WORD_HI = 5'h10;
  localparam logic [7:0] BIT_ONE = 8'h01;

endpackage

// File: src/calsbo_regfile.sv
/*
  General register file: eight longword registers, two read ports whose data
  come out of registers one cycle after the address, and one write port.
  Assumes a single clock; a read of the address being written returns old data.
*/
`timescale 1ns/1ns
`default_nettype none

module calsbo_regfile #(
  parameter int unsigned DEPTH = 8,
  parameter int unsigned WIDTH = 32,
  parameter int unsigned AW = 3
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cke,
  // read ports
  input wire logic [AW-1:0] raddr_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [WIDTH-1:0] rdata_a_q,
  output logic [WIDTH-1:0] rdata_b_q,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rda;
    logic [WIDTH-1:0] rdb;
  } calsbo_rf_t;

  calsbo_rf_t s_q;
  calsbo_rf_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.rda = s_q.mem[raddr_a];
    s_d.rdb = s_q.mem[raddr_b];
    if (we) begin
      s_d.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else if (cke) begin
      s_q <= s_d;
    end
  end

  assign rdata_a_q = s_q.rda;
  assign rdata_b_q = s_q.rdb;

endmodule

`default_nettype wire

// File: src/calsbo_core.sv
/*
  Execution datapath: divide, compare, negate, extend, logic, shift, rotate
  and single-bit operations on the general registers or a memory byte.
  Assumes one command at a time, a same-clock memory port with an ack, and
  registers preloaded through the load port while the core is idle.
*/
`timescale 1ns/1ns
`default_nettype none

module calsbo_core
  import calsbo_pkg::*;
#(
  parameter int unsigned ADDR_W = 24
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cke,
  // command
  input wire logic cmd_valid,
  input wire calsbo_pkg::calsbo_op_t cmd_op,
  input wire logic [1:0] cmd_size,
  input wire logic [3:0] cmd_dst,
  input wire logic [3:0] cmd_src,
  input wire logic [calsbo_pkg::DATA_W-1:0] cmd_imm,
  input wire logic cmd_use_imm,
  input wire logic cmd_bit_from_reg,
  input wire logic cmd_mem,
  input wire logic [ADDR_W-1:0] cmd_addr,
  output logic cmd_ready_q,
  output logic done_q,
  output logic [calsbo_pkg::DATA_W-1:0] result_q,
  output logic [3:0] flags_q,
  // register preload
  input wire logic load_valid,
  input wire logic [calsbo_pkg::GREG_AW-1:0] load_idx,
  input wire logic [calsbo_pkg::DATA_W-1:0] load_data,
  // memory byte port
  output logic mem_req_q,
  output logic mem_we_q,
  output logic [ADDR_W-1:0] mem_addr_q,
  output logic [calsbo_pkg::BYTE_W-1:0] mem_wdata_q,
  input wire logic mem_ack,
  input wire logic [calsbo_pkg::BYTE_W-1:0] mem_rdata
);

  import calsbo_pkg::*;

  typedef struct packed {
    calsbo_state_t st;
    calsbo_op_t op;
    logic [1:0] size;
    logic [3:0] dst;
    logic [3:0] src;
    logic [DATA_W-1:0] imm;
    logic use_imm;
    logic bit_reg;
    logic mem;
    logic [BYTE_W-1:0] mbyte;
    logic ready;
    logic done;
    logic [DATA_W-1:0] result;
    logic [3:0] flags;
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] wdata;
  } calsbo_core_t;

  localparam calsbo_core_t CORE_RESET = '{
    st: ST_IDLE, op: unsigned_divide_op, ready: 1'b1, flags: FLAGS_RESET, default: '0
  };

  // operand fields: byte hi_sel picks bits 15:8, word hi_sel the upper half of the same register
  function automatic logic [31:0] fld_mask(input logic [1:0] sz);
    case (sz)
      SZ_BYTE: fld_mask = MASK_BYTE;
      SZ_WORD: fld_mask = MASK_WORD;
      default: fld_mask = MASK_LONG;
    endcase
  endfunction

  function automatic logic [4:0] fld_top(input logic [1:0] sz);
    case (sz)
      SZ_BYTE: fld_top = TOP_BYTE;
      SZ_WORD: fld_top = TOP_WORD;
      default: fld_top = TOP_LONG;
    endcase
  endfunction

  function automatic logic [4:0] fld_shift(input logic hi_sel, input logic [1:0] sz);
    if (!hi_sel || sz == SZ_LONG) begin
      fld_shift = SH_NONE;
    end else begin
      fld_shift = (sz == SZ_BYTE) ? SH_BYTE_HI : SH_WORD_HI;
    end
  endfunction

  function automatic logic [31:0] get_fld(input logic [31:0] r, input logic hi_sel,
                                          input logic [1:0] sz);
    get_fld = (r >> fld_shift(hi_sel, sz)) & fld_mask(sz);
  endfunction

  function automatic logic [31:0] put_fld(input logic [31:0] r, input logic hi_sel,
                                          input logic [1:0] sz, input logic [31:0] v);
    logic [4:0] sh;
    sh = fld_shift(hi_sel, sz);
    put_fld = (r & ~(fld_mask(sz) << sh)) | ((v & fld_mask(sz)) << sh);
  endfunction

  function automatic logic fld_msb(input logic [31:0] v, input logic [1:0] sz);
    fld_msb = v[fld_top(sz)];
  endfunction

  function automatic logic fld_zero(input logic [31:0] v, input logic [1:0] sz);
    fld_zero = ((v & fld_mask(sz)) == WORD_ZERO);
  endfunction

  function automatic logic [31:0] sext(input logic [31:0] v, input logic [1:0] sz);
    sext = fld_msb(v, sz) ? (v | ~fld_mask(sz)) : (v & fld_mask(sz));
  endfunction

  function automatic logic is_bit_op(input calsbo_op_t op);
    // illegal codes above the last bit op must not start a memory read
    is_bit_op = (op >= bit_force_one_op) && (op <= inverted_bit_and_carry_op);
  endfunction

  function automatic logic is_bit_write(input calsbo_op_t op);
    is_bit_write = (op == bit_force_one_op) || (op == bit_force_zero_op) ||
                   (op == bit_toggle_op);
  endfunction

  calsbo_core_t s_q;
  calsbo_core_t s_d;

  logic [DATA_W-1:0] d_reg;
  logic [DATA_W-1:0] s_reg;
  logic [GREG_AW-1:0] raddr_a;
  logic [GREG_AW-1:0] raddr_b;
  logic rf_we;
  logic [GREG_AW-1:0] rf_waddr;
  logic [DATA_W-1:0] rf_wdata;
  logic [DATA_W-1:0] dst_fld;
  logic [DATA_W-1:0] src_fld;
  logic [DATA_W-1:0] byte_fld;
  logic [DATA_W-1:0] src_byte;
  logic [BYTE_W-1:0] opb;
  logic [BYTE_W-1:0] nb;
  logic [BITNO_W-1:0] bit_idx;
  logic bit_val;
  logic [DATA_W-1:0] res;
  logic [3:0] nf;
  logic wr_reg;
  logic [1:0] dvd_sz;
  logic [1:0] dvs_sz;
  logic [DATA_W-1:0] a32;
  logic [DATA_W-1:0] b32;
  logic [DATA_W-1:0] q32;
  logic [DATA_W-1:0] r32;
  logic [DATA_W-1:0] cmp_x;
  logic [DATA_W-1:0] cmp_y;
  logic [1:0] low_sz;
  logic [DATA_W-1:0] low_part;
  logic out_bit;
  logic fill;
  logic [4:0] top;

  calsbo_regfile #(
    .DEPTH(GREG_COUNT),
    .WIDTH(DATA_W),
    .AW(GREG_AW)
  ) u_regs (
    .mclk(mclk),
    .rstn(rstn),
    .cke(cke),
    .raddr_a(raddr_a),
    .raddr_b(raddr_b),
    .rdata_a_q(d_reg),
    .rdata_b_q(s_reg),
    .we(rf_we),
    .waddr(rf_waddr),
    .wdata(rf_wdata)
  );

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    // registers are read from the command while idle so data are ready in exec
    raddr_a = (s_q.st == ST_IDLE) ? cmd_dst[GREG_AW-1:0] : s_q.dst[GREG_AW-1:0];
    raddr_b = (s_q.st == ST_IDLE) ? cmd_src[GREG_AW-1:0] : s_q.src[GREG_AW-1:0];
    rf_we = 1'b0;
    rf_waddr = s_q.dst[GREG_AW-1:0];
    rf_wdata = d_reg;
    top = fld_top(s_q.size);
    dst_fld = get_fld(d_reg, s_q.dst[3], s_q.size);
    src_fld = s_q.use_imm ? (s_q.imm & fld_mask(s_q.size)) :
              get_fld(s_reg, s_q.src[3], s_q.size);
    byte_fld = get_fld(d_reg, s_q.dst[3], SZ_BYTE);
    src_byte = get_fld(s_reg, s_q.src[3], SZ_BYTE);
    opb = s_q.mem ? s_q.mbyte : byte_fld[BYTE_W-1:0];
    // the inverted form takes its bit number only from the immediate
    bit_idx = (s_q.bit_reg && s_q.op != inverted_bit_and_carry_op) ?
              src_byte[BITNO_W-1:0] : s_q.imm[BITNO_W-1:0];
    bit_val = opb[bit_idx];
    nb = opb;
    res = WORD_ZERO;
    nf = s_q.flags;
    wr_reg = 1'b0;
    // divider: byte size is word dividend over byte divisor, word size long over word
    dvd_sz = (s_q.size == SZ_BYTE) ? SZ_WORD : SZ_LONG;
    dvs_sz = (s_q.size == SZ_BYTE) ? SZ_BYTE : SZ_WORD;
    a32 = get_fld(d_reg, s_q.dst[3], dvd_sz);
    b32 = get_fld(s_reg, s_q.src[3], dvs_sz);
    if (s_q.op == signed_divide_op) begin
      a32 = sext(a32, dvd_sz);
      b32 = sext(b32, dvs_sz);
    end
    q32 = WORD_ZERO;
    r32 = WORD_ZERO;
    // a zero divisor would give an unknown quotient, so the divide is skipped
    if (b32 != WORD_ZERO) begin
      if (s_q.op == signed_divide_op) begin
        q32 = $signed(a32) / $signed(b32);
        r32 = $signed(a32) % $signed(b32);
      end else begin
        q32 = a32 / b32;
        r32 = a32 % b32;
      end
    end
    cmp_x = (s_q.op == negate_op) ? WORD_ZERO : dst_fld;
    cmp_y = (s_q.op == negate_op) ? dst_fld : src_fld;
    low_sz = (s_q.size == SZ_WORD) ? SZ_BYTE : SZ_WORD;
    low_part = dst_fld & fld_mask(low_sz);
    out_bit = 1'b0;
    fill = 1'b0;

    unique case (s_q.op)
      unsigned_divide_op, signed_divide_op: begin
        // remainder in the upper half, quotient in the lower half
        res = ((r32 & fld_mask(dvs_sz)) << fld_top(dvs_sz)) << 1;
        res = res | (q32 & fld_mask(dvs_sz));
        wr_reg = (b32 != WORD_ZERO);
        nf[FLAG_N] = fld_msb(b32, dvs_sz);
        nf[FLAG_Z] = (b32 == WORD_ZERO);
        rf_wdata = put_fld(d_reg, s_q.dst[3], dvd_sz, res);
      end
      compare_op, negate_op: begin
        res = (cmp_x - cmp_y) & fld_mask(s_q.size);
        wr_reg = (s_q.op == negate_op);
        nf[FLAG_N] = res[top];
        nf[FLAG_Z] = fld_zero(res, s_q.size);
        nf[FLAG_C] = (cmp_x < cmp_y);
        nf[FLAG_V] = (cmp_x[top] != cmp_y[top]) && (res[top] != cmp_x[top]);
      end
      sign_extend_op, zero_extend_op: begin
        res = low_part;
        if (s_q.op == sign_extend_op && fld_msb(low_part, low_sz)) begin
          res = low_part | (fld_mask(s_q.size) & ~fld_mask(low_sz));
        end
        wr_reg = 1'b1;
        nf[FLAG_N] = res[top];
        nf[FLAG_Z] = fld_zero(res, s_q.size);
        nf[FLAG_V] = 1'b0;
      end
      and_op, or_op, xor_op, complement_op: begin
        case (s_q.op)
          and_op: res = dst_fld & src_fld;
          or_op: res = dst_fld | src_fld;
          xor_op: res = dst_fld ^ src_fld;
          default: res = ~dst_fld & fld_mask(s_q.size);
        endcase
        wr_reg = 1'b1;
        nf[FLAG_N] = res[top];
        nf[FLAG_Z] = fld_zero(res, s_q.size);
        nf[FLAG_V] = 1'b0;
      end
      arith_left_shift_op, logic_left_shift_op, rotate_left_op, carry_rotate_left_op: begin
        out_bit = dst_fld[top];
        if (s_q.op == rotate_left_op) begin
          fill = out_bit;
        end else if (s_q.op == carry_rotate_left_op) begin
          fill = s_q.flags[FLAG_C];
        end
        res = ((dst_fld << 1) | 32'(fill)) & fld_mask(s_q.size);
        wr_reg = 1'b1;
        nf[FLAG_C] = out_bit;
        nf[FLAG_N] = res[top];
        nf[FLAG_Z] = fld_zero(res, s_q.size);
        nf[FLAG_V] = (s_q.op == arith_left_shift_op) && (res[top] != out_bit);
      end
      arith_right_shift_op, logic_right_shift_op, rotate_right_op,
      carry_rotate_right_op: begin
        out_bit = dst_fld[0];
        if (s_q.op == arith_right_shift_op) begin
          fill = dst_fld[top];
        end else if (s_q.op == rotate_right_op) begin
          fill = out_bit;
        end else if (s_q.op == carry_rotate_right_op) begin
          fill = s_q.flags[FLAG_C];
        end
        res = (dst_fld >> 1) | (32'(fill) << top);
        wr_reg = 1'b1;
        nf[FLAG_C] = out_bit;
        nf[FLAG_N] = res[top];
        nf[FLAG_Z] = fld_zero(res, s_q.size);
        nf[FLAG_V] = 1'b0;
      end
      bit_force_one_op, bit_force_zero_op, bit_toggle_op: begin
        case (s_q.op)
          bit_force_one_op: nb = opb | (BIT_ONE << bit_idx);
          bit_force_zero_op: nb = opb & ~(BIT_ONE << bit_idx);
          default: nb = opb ^ (BIT_ONE << bit_idx);
        endcase
        res = 32'(nb);
        wr_reg = !s_q.mem;
        rf_wdata = put_fld(d_reg, s_q.dst[3], SZ_BYTE, res);
      end
      bit_probe_op: begin
        res = 32'(opb);
        nf[FLAG_Z] = !bit_val;
      end
      bit_and_carry_op: begin
        res = 32'(opb);
        nf[FLAG_C] = s_q.flags[FLAG_C] & bit_val;
      end
      inverted_bit_and_carry_op: begin
        res = 32'(opb);
        nf[FLAG_C] = s_q.flags[FLAG_C] & !bit_val;
      end
      default: begin
        res = WORD_ZERO;
      end
    endcase
    if (s_q.op != unsigned_divide_op && s_q.op != signed_divide_op && !is_bit_write(s_q.op))
    begin
      rf_wdata = put_fld(d_reg, s_q.dst[3], s_q.size, res);
    end

    unique case (s_q.st)
      ST_IDLE: begin
        if (load_valid) begin
          rf_we = 1'b1;
          rf_waddr = load_idx;
          rf_wdata = load_data;
        end
        if (cmd_valid) begin
          s_d.op = cmd_op;
          s_d.size = cmd_size;
          s_d.dst = cmd_dst;
          s_d.src = cmd_src;
          s_d.imm = cmd_imm;
          s_d.use_imm = cmd_use_imm;
          s_d.bit_reg = cmd_bit_from_reg;
          s_d.mem = cmd_mem && is_bit_op(cmd_op);
          s_d.ready = 1'b0;
          if (cmd_mem && is_bit_op(cmd_op)) begin
            s_d.st = ST_MEMRD;
            s_d.req = 1'b1;
            s_d.we = 1'b0;
            s_d.addr = cmd_addr;
          end else begin
            s_d.st = ST_EXEC;
          end
        end
      end
      ST_MEMRD: begin
        if (mem_ack) begin
          s_d.mbyte = mem_rdata;
          s_d.req = 1'b0;
          s_d.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        rf_we = wr_reg;
        s_d.result = res;
        s_d.flags = nf;
        if (s_q.mem && is_bit_write(s_q.op)) begin
          // the whole byte goes back, only one bit of it changed
          s_d.st = ST_MEMWR;
          s_d.req = 1'b1;
          s_d.we = 1'b1;
          s_d.wdata = nb;
        end else begin
          s_d.st = ST_IDLE;
          s_d.done = 1'b1;
          s_d.ready = 1'b1;
        end
      end
      ST_MEMWR: begin
        if (mem_ack) begin
          s_d.req = 1'b0;
          s_d.we = 1'b0;
          s_d.st = ST_IDLE;
          s_d.done = 1'b1;
          s_d.ready = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_q <= CORE_RESET;
    end else if (cke) begin
      s_q <= s_d;
    end
  end

  assign cmd_ready_q = s_q.ready;
  assign done_q = s_q.done;
  assign result_q = s_q.result;
  assign flags_q = s_q.flags;
  assign mem_req_q = s_q.req;
  assign mem_we_q = s_q.we;
  assign mem_addr_q = s_q.addr;
  assign mem_wdata_q = s_q.wdata;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  compare_keeps_dest_a: assert property (
    (s_q.st == ST_EXEC && s_q.op == compare_op) |-> !rf_we)
    else $error("compare wrote its destination");

  negate_sum_zero_a: assert property (
    (s_q.st == ST_EXEC && s_q.op == negate_op) |->
    rf_we && fld_zero(32'(get_fld(rf_wdata, s_q.dst[3], s_q.size) + dst_fld), s_q.size))
    else $error("negate result plus operand is not zero");

  complement_inverts_a: assert property (
    (s_q.st == ST_EXEC && s_q.op == complement_op) |->
    get_fld(rf_wdata, s_q.dst[3], s_q.size) == (~dst_fld & fld_mask(s_q.size)))
    else $error("complement result wrong");

  probe_zero_flag_a: assert property (
    (s_q.st == ST_EXEC && s_q.op == bit_probe_op && cke) |=>
    flags_q[FLAG_Z] == !$past(bit_val) && !$past(rf_we))
    else $error("bit probe zero flag wrong or operand written");

  band_carry_a: assert property (
    (s_q.st == ST_EXEC && s_q.op == bit_and_carry_op && cke) |=>
    flags_q[FLAG_C] == ($past(s_q.flags[FLAG_C]) & $past(bit_val)))
    else $error("bit and carry result wrong");

  inv_band_imm_a: assert property (
    (s_q.st == ST_EXEC && s_q.op == inverted_bit_and_carry_op) |->
    bit_idx == s_q.imm[BITNO_W-1:0])
    else $error("inverted bit and carry used a register bit number");

  carry_rot_out_a: assert property (
    (s_q.st == ST_EXEC && s_q.op == carry_rotate_left_op && cke) |=>
    flags_q[FLAG_C] == $past(dst_fld[top]) && result_q[0] == $past(s_q.flags[FLAG_C]))
    else $error("carry rotate left lost the carry loop");

  sext_upper_a: assert property (
    (s_q.st == ST_EXEC && s_q.op == sign_extend_op) |->
    fld_msb(res, s_q.size) == fld_msb(low_part, low_sz))
    else $error("sign extension upper bit wrong");

  memwr_after_read_a: assert property (
    $rose(mem_req_q && mem_we_q) |-> $past(s_q.st == ST_EXEC) && is_bit_write(s_q.op))
    else $error("memory write without read-modify sequence");

endmodule

`default_nettype wire

// File: test/calsbo_core_tb.sv
/*
  Self-checking bench of the execution datapath: divide, compare, negate,
  extend, logic, shift, rotate and bit operations on registers and memory.
  Assumes calsbo_pkg and calsbo_core are compiled before it.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end

module calsbo_core_tb;
  import calsbo_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic cke = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_use_imm = 1'b0;
  logic cmd_bit_from_reg = 1'b0;
  logic cmd_mem = 1'b0;
  calsbo_op_t cmd_op = unsigned_divide_op;
  logic [1:0] cmd_size = 2'h0;
  logic [3:0] cmd_dst = 4'h0;
  logic [3:0] cmd_src = 4'h0;
  logic [31:0] cmd_imm = 32'h0000_0000;
  logic [31:0] load_data = 32'h0000_0000;
  logic [23:0] cmd_addr = 24'h12_3456;
  logic load_valid = 1'b0;
  logic [2:0] load_idx = 3'h0;
  logic mem_ack = 1'b0;
  logic [7:0] mem_rdata = 8'h00;
  logic [7:0] mem_b = 8'h0f;
  logic [23:0] w_addr = 24'h00_0000;
  logic cmd_ready_q, done_q, mem_req_q, mem_we_q;
  logic [31:0] result_q;
  logic [3:0] flags_q;
  logic [23:0] mem_addr_q;
  logic [7:0] mem_wdata_q;
  int err_total = 0;
  int tests_run = 0;
  int rd_n = 0;
  int wr_n = 0;

  calsbo_core uut (.mclk, .rstn, .cke, .cmd_valid, .cmd_op, .cmd_size, .cmd_dst, .cmd_src,
    .cmd_imm, .cmd_use_imm, .cmd_bit_from_reg, .cmd_mem, .cmd_addr, .cmd_ready_q, .done_q,
    .result_q, .flags_q, .load_valid, .load_idx, .load_data, .mem_req_q, .mem_we_q,
    .mem_addr_q, .mem_wdata_q, .mem_ack, .mem_rdata);

  initial begin
    forever #20 mclk = ~mclk;
  end

  // memory byte answers one cycle after the request; idle data keeps changing
  always @(posedge mclk) begin
    if (mem_req_q && !mem_ack) begin
      mem_ack <= 1'b1;
      mem_rdata <= mem_b;
      if (mem_we_q) begin
        mem_b <= mem_wdata_q;
        w_addr <= mem_addr_q;
        wr_n++;
      end else begin
        rd_n++;
      end
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end

  task automatic final_report;
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic ld(input logic [2:0] i, input logic [31:0] v);
    @(posedge mclk);
    load_valid <= 1'b1;
    load_idx <= i;
    load_data <= v;
    @(posedge mclk);
    load_valid <= 1'b0;
  endtask

  // f = {use_imm, bit_from_reg, mem}
  task automatic run(input calsbo_op_t op, input logic [1:0] sz, input logic [3:0] d,
                     input logic [3:0] s, input logic [31:0] im, input logic [2:0] f);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_size <= sz;
    cmd_dst <= d;
    cmd_src <= s;
    cmd_imm <= im;
    {cmd_use_imm, cmd_bit_from_reg, cmd_mem} <= f;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    #1;
    for (int k = 0; k < 30 && done_q !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    `CHK("done", 1'b1, done_q)
  endtask

  task automatic t_div;
    ld(0, 32'h0000_0064);
    ld(1, 32'h0000_0007);
    ld(2, 32'h0001_0000);
    ld(3, 32'h0000_0003);
    run(unsigned_divide_op, SZ_BYTE, 4'h0, 4'h1, 32'h0, 3'h0);
    `CHK("divu_b", 32'h0000_020e, result_q)
    run(unsigned_divide_op, SZ_WORD, 4'h2, 4'h3, 32'h0, 3'h0);
    `CHK("divu_w", 32'h0001_5555, result_q)
    ld(0, 32'h0000_ff9c);
    run(signed_divide_op, SZ_BYTE, 4'h0, 4'h1, 32'h0, 3'h0);
    `CHK("divs_b", 32'h0000_fef2, result_q)
    // register 4 still holds its reset zero: divide by zero is refused
    run(unsigned_divide_op, SZ_BYTE, 4'h0, 4'h4, 32'h0, 3'h0);
    `CHK("div0_z", 1'b1, flags_q[FLAG_Z])
    `CHK("div0_res", 32'h0000_0000, result_q)
  endtask

  // a load offered while the clock enable is low must be lost
  task automatic t_cke;
    ld(4, 32'h0000_00f0);
    @(posedge mclk);
    cke <= 1'b0;
    load_valid <= 1'b1;
    load_idx <= 3'h4;
    load_data <= 32'h0000_0000;
    repeat (3) @(posedge mclk);
    load_valid <= 1'b0;
    cke <= 1'b1;
    run(complement_op, SZ_BYTE, 4'h4, 4'h0, 32'h0, 3'h0);
    `CHK("cke_hold", 32'h0000_000f, result_q)
  endtask

  task automatic t_cmp_neg;
    ld(5, 32'h0000_1234);
    run(compare_op, SZ_WORD, 4'h5, 4'h0, 32'h0000_1234, 3'h4);
    `CHK("cmp_w_flags", 4'h4, flags_q)
    run(compare_op, SZ_BYTE, 4'h5, 4'h0, 32'h0000_0035, 3'h4);
    `CHK("cmp_b", 32'h0000_00ff, result_q)
    `CHK("cmp_b_flags", 4'h9, flags_q)
    // destination must still hold its value
    run(compare_op, SZ_LONG, 4'h5, 4'h0, 32'h0, 3'h4);
    `CHK("cmp_keep", 32'h0000_1234, result_q)
    ld(6, 32'h0000_0001);
    run(negate_op, SZ_LONG, 4'h6, 4'h0, 32'h0, 3'h0);
    `CHK("neg_l", 32'hffff_ffff, result_q)
  endtask

  task automatic t_ext_logic;
    ld(7, 32'h1234_5680);
    run(sign_extend_op, SZ_WORD, 4'h7, 4'h0, 32'h0, 3'h0);
    `CHK("sign_extend_op_w", 32'h0000_ff80, result_q)
    run(sign_extend_op, SZ_LONG, 4'h7, 4'h0, 32'h0, 3'h0);
    `CHK("sign_extend_op_l", 32'hffff_ff80, result_q)
    ld(7, 32'h1234_8680);
    run(zero_extend_op, SZ_WORD, 4'h7, 4'h0, 32'h0, 3'h0);
    `CHK("zero_extend_op_w", 32'h0000_0080, result_q)
    ld(0, 32'hf0f0_f0f0);
    ld(1, 32'h0ff0_0ff0);
    run(and_op, SZ_LONG, 4'h0, 4'h1, 32'h0, 3'h0);
    `CHK("and_l", 32'h00f0_00f0, result_q)
    run(or_op, SZ_BYTE, 4'h0, 4'h0, 32'h0000_000f, 3'h4);
    `CHK("or_b", 32'h0000_00ff, result_q)
    run(xor_op, SZ_WORD, 4'h0, 4'h0, 32'h0000_ffff, 3'h4);
    `CHK("xor_w", 32'h0000_ff00, result_q)
    run(complement_op, SZ_LONG, 4'h0, 4'h0, 32'h0, 3'h0);
    `CHK("not_l", 32'hff0f_00ff, result_q)
  endtask

  // high byte of register 1, one position per operation, carry chained
  task automatic t_shift;
    logic [7:0] e [8] = '{8'h00, 8'hc0, 8'h00, 8'h40, 8'h01, 8'h40, 8'h00, 8'hc0};
    logic [7:0] c = 8'h55;
    for (int i = 0; i < 8; i++) begin
      ld(1, 32'h0000_8000);
      run(calsbo_op_t'(int'(arith_left_shift_op) + i), SZ_BYTE, 4'h9, 4'h0, 32'h0, 3'h0);
      `CHK("shift", {24'h00_0000, e[i]}, result_q)
      `CHK("shift_c", c[i], flags_q[FLAG_C])
    end
    ld(1, 32'h8000_0001);
    run(arith_right_shift_op, SZ_LONG, 4'h1, 4'h0, 32'h0, 3'h0);
    `CHK("arith_right_shift_op_l", 32'hc000_0000, result_q)
  endtask

  task automatic t_bits;
    ld(2, 32'h0000_0055);
    ld(3, 32'h0000_0002);
    run(bit_force_one_op, SZ_BYTE, 4'h2, 4'h3, 32'h1, 3'h0);
    `CHK("bit_force_one_op", 32'h0000_0057, result_q)
    run(bit_force_zero_op, SZ_BYTE, 4'h2, 4'h3, 32'h0, 3'h2);
    `CHK("bit_force_zero_op", 32'h0000_0053, result_q)
    run(bit_toggle_op, SZ_BYTE, 4'h2, 4'h3, 32'h7, 3'h0);
    `CHK("bit_toggle_op", 32'h0000_00d3, result_q)
    run(bit_probe_op, SZ_BYTE, 4'h2, 4'h3, 32'h3, 3'h0);
    `CHK("probe0", 1'b1, flags_q[FLAG_Z])
    run(bit_probe_op, SZ_BYTE, 4'h2, 4'h3, 32'h7, 3'h0);
    `CHK("probe1", 1'b0, flags_q[FLAG_Z])
    `CHK("probe_keep", 32'h0000_00d3, result_q)
    run(bit_and_carry_op, SZ_BYTE, 4'h2, 4'h3, 32'h0, 3'h0);
    `CHK("band", 1'b1, flags_q[FLAG_C])
    // register bit number must be ignored here: bit 2 would leave carry set
    run(inverted_bit_and_carry_op, SZ_BYTE, 4'h2, 4'h3, 32'h0, 3'h2);
    `CHK("inverted_bit_and_carry_op", 1'b0, flags_q[FLAG_C])
  endtask

  task automatic t_mem;
    run(bit_force_one_op, SZ_BYTE, 4'h0, 4'h0, 32'h7, 3'h1);
    `CHK("mem_byte", 8'h8f, mem_b)
    `CHK("mem_rw", 64'h1_0000_0001, {rd_n, wr_n})
    `CHK("mem_addr", 24'h12_3456, w_addr)
    run(bit_probe_op, SZ_BYTE, 4'h0, 4'h0, 32'h7, 3'h1);
    `CHK("mem_probe", 1'b0, flags_q[FLAG_Z])
    `CHK("mem_nowr", 1, wr_n)
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    #1;
    `CHK("rst_ready", 1'b1, cmd_ready_q)
    t_div;
    t_cmp_neg;
    t_ext_logic;
    t_shift;
    t_bits;
    t_mem;
    t_cke;
    final_report;
  end

  // about 170 cycles of work expected
  initial begin
    repeat (4000) @(posedge mclk);
    err_total++;
    final_report;
  end
endmodule
`default_nettype wire
